// ### comparator_cfg.svh
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH

// register byte offsets
`define CMP_CTRL_OFFSET 12'h000
`define CMP_LADDER_OFFSET 12'h004

// reset values
`define CMP_CTRL_RESET 32'h0000_0000
`define CMP_LADDER_RESET 32'h0000_0000

// bits that software may store
`define CMP_CTRL_WMASK 32'h000F_FFFF
`define CMP_LADDER_WMASK 32'h0000_007F

// control field positions
`define CMP_CHAN0_EN_BIT 0
`define CMP_CHAN1_EN_BIT 1
`define CMP_LEVEL_SEL_BIT 2
`define CMP_POLARITY_BIT 3
`define CMP_BOTH_EDGES_BIT 4
`define CMP_ORIENT_BIT 5
`define CMP_CHAN0_SYNC_BIT 6
`define CMP_CHAN1_SYNC_BIT 7
`define CMP_CHAN0_PLUS_LSB 8
`define CMP_CHAN0_MINUS_LSB 11
`define CMP_CHAN1_PLUS_LSB 14
`define CMP_CHAN1_MINUS_LSB 17
`define CMP_SEL_W 3
`define CMP_IRQ_CLEAR_BIT 20
`define CMP_CHAN0_STATE_BIT 21
`define CMP_CHAN1_STATE_BIT 22

// ladder field positions
`define CMP_LADDER_EN_BIT 0
`define CMP_LADDER_LEVEL_LSB 1
`define CMP_LADDER_LEVEL_W 5
`define CMP_LADDER_REF_BIT 6

`endif

// ### comparator_channel.sv
`timescale 1ns/1ps
module comparator_channel (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // analog core result and controls
    input wire logic raw,
    input wire logic enable,
    input wire logic sync_select,
    // results
    output logic out_pin,
    output logic state,
    output logic rise,
    output logic fall
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // two-stage synchroniser on the bus clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            // gated so a stale value from a powered-down core never reaches the edge detector
            meta_reg <= enable & raw;
            sync_reg <= meta_reg;
        end
    end

    // disabled channel reads low
    assign state = enable & sync_reg;

    // previous state for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= state;
        end
    end

    assign rise = state & ~prev_reg;
    assign fall = ~state & prev_reg;

    // registered or direct output to timers and pin
    assign out_pin = sync_select ? state : (enable & raw);

endmodule

// ### comparator_control.sv
`timescale 1ns/1ps
`include "comparator_cfg.svh"
module comparator_control #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparator cores
    input wire logic chan0_raw,
    input wire logic chan1_raw,
    output logic chan0_enable,
    output logic chan1_enable,
    output comparator_pkg::switch_vec_t chan0_plus_switch,
    output comparator_pkg::switch_vec_t chan0_minus_switch,
    output comparator_pkg::switch_vec_t chan1_plus_switch,
    output comparator_pkg::switch_vec_t chan1_minus_switch,
    // voltage ladder
    output logic ladder_enable,
    output logic [4:0] ladder_level,
    output logic ladder_ref_select,
    // pins and timers
    output logic chan0_output_pin,
    output logic chan1_output_pin,
    output logic relax_osc_output_pin,
    // interrupts
    output logic chan0_irq,
    output logic chan1_irq,
    output logic irq
);

    logic [31:0] ctrl_reg;
    logic [31:0] ladder_reg;
    logic [31:0] prdata_reg;
    logic [1:0] pending_reg;
    logic relax_osc_output_pin_reg;
    logic setup_phase;
    logic wr_access;
    logic wr_ctrl;
    logic wr_ladder;
    logic clear_req;
    logic [1:0] addr_hit;
    logic [1:0] raw_vec;
    logic [1:0] enable_vec;
    logic [1:0] sync_vec;
    logic [1:0] pin_vec;
    logic [1:0] state_vec;
    logic [1:0] rise_vec;
    logic [1:0] fall_vec;
    logic [1:0] hit_vec;
    logic [1:0] chan_irq_vec;
    logic osc_set;
    logic osc_reset;

    // address decode shared by read and write paths
    function automatic logic [1:0] decode_addr(input logic [ADDR_W-1:0] addr);
        logic [1:0] hit;
        hit = 2'b00;
        if (addr == ADDR_W'(`CMP_CTRL_OFFSET)) begin
            hit[0] = 1'b1;
        end else if (addr == ADDR_W'(`CMP_LADDER_OFFSET)) begin
            hit[1] = 1'b1;
        end
        return hit;
    endfunction

    // apb phases; one decode shared by every path
    assign addr_hit = decode_addr(paddr);
    assign setup_phase = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign wr_ctrl = wr_access & addr_hit[0];
    assign wr_ladder = wr_access & addr_hit[1];
    assign clear_req = wr_ctrl & pwdata[`CMP_IRQ_CLEAR_BIT];

    // zero-wait slave, error on unmapped word
    assign pready = 1'b1;
    assign pslverr = psel & penable & (addr_hit == 2'b00);

    // control register, only configuration bits stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CMP_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata & `CMP_CTRL_WMASK;
        end
    end

    // ladder register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_reg <= `CMP_LADDER_RESET;
        end else if (wr_ladder) begin
            ladder_reg <= pwdata & `CMP_LADDER_WMASK;
        end
    end

    // read data captured in setup so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata_reg <= 32'h0000_0000;
            if (addr_hit[0]) begin
                prdata_reg <= ctrl_reg;
                prdata_reg[`CMP_CHAN0_STATE_BIT] <= state_vec[0];
                prdata_reg[`CMP_CHAN1_STATE_BIT] <= state_vec[1];
            end else if (addr_hit[1]) begin
                prdata_reg <= ladder_reg;
            end
        end
    end

    assign prdata = prdata_reg;

    // control fields to the analog cores
    assign chan0_enable = ctrl_reg[`CMP_CHAN0_EN_BIT];
    assign chan1_enable = ctrl_reg[`CMP_CHAN1_EN_BIT];
    assign ladder_enable = ladder_reg[`CMP_LADDER_EN_BIT];
    assign ladder_level = ladder_reg[`CMP_LADDER_LEVEL_LSB +: `CMP_LADDER_LEVEL_W];
    assign ladder_ref_select = ladder_reg[`CMP_LADDER_REF_BIT];

    // input multiplexers; codes 5 and 6 reach the other core's pins 0 and 1
    input_select u_chan0_plus (
        .sel(ctrl_reg[`CMP_CHAN0_PLUS_LSB +: `CMP_SEL_W]),
        .switch_vec(chan0_plus_switch)
    );

    input_select u_chan0_minus (
        .sel(ctrl_reg[`CMP_CHAN0_MINUS_LSB +: `CMP_SEL_W]),
        .switch_vec(chan0_minus_switch)
    );

    input_select u_chan1_plus (
        .sel(ctrl_reg[`CMP_CHAN1_PLUS_LSB +: `CMP_SEL_W]),
        .switch_vec(chan1_plus_switch)
    );

    input_select u_chan1_minus (
        .sel(ctrl_reg[`CMP_CHAN1_MINUS_LSB +: `CMP_SEL_W]),
        .switch_vec(chan1_minus_switch)
    );

    // per-channel vectors for the generate loop
    assign raw_vec = {chan1_raw, chan0_raw};
    assign enable_vec = {ctrl_reg[`CMP_CHAN1_EN_BIT], ctrl_reg[`CMP_CHAN0_EN_BIT]};
    assign sync_vec = {ctrl_reg[`CMP_CHAN1_SYNC_BIT], ctrl_reg[`CMP_CHAN0_SYNC_BIT]};

    // output conditioning per comparator
    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            comparator_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .raw(raw_vec[i]),
                .enable(enable_vec[i]),
                .sync_select(sync_vec[i]),
                .out_pin(pin_vec[i]),
                .state(state_vec[i]),
                .rise(rise_vec[i]),
                .fall(fall_vec[i])
            );
        end
    endgenerate

    assign chan0_output_pin = pin_vec[0];
    assign chan1_output_pin = pin_vec[1];

    // qualifying edges: both edges override the polarity choice
    always_comb begin
        if (ctrl_reg[`CMP_BOTH_EDGES_BIT]) begin
            hit_vec = rise_vec | fall_vec;
        end else if (ctrl_reg[`CMP_POLARITY_BIT]) begin
            hit_vec = rise_vec;
        end else begin
            hit_vec = fall_vec;
        end
    end

    // sticky edge requests; a new edge wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= 2'b00;
        end else begin
            pending_reg <= ((clear_req ? 2'b00 : pending_reg) | hit_vec);
        end
    end

    // level mode follows state, edge mode shows the pending flag
    assign chan_irq_vec = ctrl_reg[`CMP_LEVEL_SEL_BIT] ? state_vec : pending_reg;
    assign chan0_irq = chan_irq_vec[0];
    assign chan1_irq = chan_irq_vec[1];
    assign irq = |chan_irq_vec;

    // orientation swaps which comparator sets and which resets
    assign osc_set = ctrl_reg[`CMP_ORIENT_BIT] ? state_vec[1] : state_vec[0];
    assign osc_reset = ctrl_reg[`CMP_ORIENT_BIT] ? state_vec[0] : state_vec[1];

    // set/reset latch forming the relaxation oscillator, reset dominant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relax_osc_output_pin_reg <= 1'b0;
        end else if (osc_reset) begin
            relax_osc_output_pin_reg <= 1'b0;
        end else if (osc_set) begin
            relax_osc_output_pin_reg <= 1'b1;
        end
    end

    assign relax_osc_output_pin = relax_osc_output_pin_reg;

endmodule

// ### comparator_control_chk.sv
`timescale 1ns/1ps
module comparator_control_chk #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // comparator side
    input wire logic chan0_raw,
    input wire logic chan0_enable,
    input wire logic chan1_enable,
    input wire comparator_pkg::switch_vec_t chan0_plus_switch,
    input wire comparator_pkg::switch_vec_t chan0_minus_switch,
    input wire comparator_pkg::switch_vec_t chan1_plus_switch,
    input wire comparator_pkg::switch_vec_t chan1_minus_switch,
    input wire logic chan0_output_pin,
    input wire logic chan1_output_pin,
    input wire logic chan0_irq,
    input wire logic chan1_irq,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic [31:0] ctrl_q;
    // shadow of the control word
    assign wr = psel && penable && pwrite && paddr == 0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= 32'h0;
        else if (wr)
            ctrl_q <= pwdata;
    end
    a_err_unmapped: assert property (psel && penable |-> pslverr == (paddr != 0 && paddr != 4))
        else $error("slave error does not match address");
    a_enable_write: assert property (wr |=> {chan1_enable, chan0_enable} == $past(pwdata[1:0]))
        else $error("enables not taken from write");
    a_disabled_low: assert property (!chan0_enable && !chan1_enable |-> !chan0_output_pin && !chan1_output_pin)
        else $error("disabled comparator drives its pin");
    a_plus_code: assert property (wr |=> chan0_plus_switch == (8'h01 << $past(pwdata[10:8]))
        && chan0_minus_switch == (8'h01 << $past(pwdata[13:11])))
        else $error("comparator 0 switches wrong");
    a_chan1_code: assert property (wr |=> chan1_plus_switch == (8'h01 << $past(pwdata[16:14]))
        && chan1_minus_switch == (8'h01 << $past(pwdata[19:17])))
        else $error("comparator 1 switches wrong");
    a_direct_out: assert property (!ctrl_q[6] |-> chan0_output_pin == (chan0_enable && chan0_raw))
        else $error("direct output not raw");
    a_edge_hold: assert property (!ctrl_q[2] && chan0_irq && !wr |=> chan0_irq)
        else $error("edge request dropped without clear");
    a_irq_or: assert property (irq == (chan0_irq || chan1_irq))
        else $error("common request wrong");
endmodule
bind comparator_control comparator_control_chk #(.ADDR_W(ADDR_W)) chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pslverr, .chan0_raw, .chan0_enable, .chan1_enable, .chan0_plus_switch, .chan0_minus_switch,
    .chan1_plus_switch, .chan1_minus_switch, .chan0_output_pin, .chan1_output_pin, .chan0_irq, .chan1_irq, .irq);

// ### comparator_control_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module comparator_control_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, r0, r1, e0, e1, o0, o1, ro, i0, i1, irq, le, lr;
    logic [4:0] ll;
    logic [3:0] pins0 = 0, pins1 = 0;
    comparator_pkg::switch_vec_t s0p, s0m, s1p, s1m;
    int n_fail = 0, comparisons = 0;
    initial forever #2 pclk = ~pclk;
    comparator_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .chan0_raw(r0), .chan1_raw(r1), .chan0_enable(e0), .chan1_enable(e1), .chan0_plus_switch(s0p),
        .chan0_minus_switch(s0m), .chan1_plus_switch(s1p), .chan1_minus_switch(s1m), .ladder_enable(le),
        .ladder_level(ll), .ladder_ref_select(lr), .chan0_output_pin(o0), .chan1_output_pin(o1),
        .relax_osc_output_pin(ro), .chan0_irq(i0), .chan1_irq(i1), .irq);
    comparator_core_model core (.pclk, .pins0, .pins1, .en0(e0), .en1(e1), .p0(s0p), .m0(s0m), .p1(s1p), .m1(s1m),
        .raw0(r0), .raw1(r1));
    task print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one apb transfer, waits for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (i >= 16) begin
            n_fail++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task set2(input logic a, input logic b);
        @(posedge pclk);
        pins0 <= {3'b0, a};
        pins1 <= {3'b0, b};
        wt(6);
    endtask
    task t_regs;
        apb(0, 12'h000, 0); `CHK(rd, 32'h0)
        apb(0, 12'h004, 0); `CHK(rd, 32'h0)
        apb(1, 12'h000, 32'hFFFFFFFF);
        apb(1, 12'h004, 32'hFFFFFFFF);
        apb(1, 12'h008, 32'h0); `CHK(err, 1'b1)
        apb(0, 12'h000, 0); `CHK(rd, 32'h000FFFFF)
        apb(0, 12'h004, 0); `CHK(rd, 32'h0000007F)
        `CHK({le, ll, lr}, 7'h7F)
        $display("test regs done");
    endtask
    task t_mux;
        for (int c = 0; c < 8; c++) begin
            apb(1, 12'h000, 32'h24900 * c);
            `CHK({s0p, s0m, s1p, s1m}, {4{8'h01 << c}})
        end
        $display("test mux done");
    endtask
    task t_irq;
        logic pol, both;
        for (int k = 0; k < 4; k++) begin
            pol = k[0];
            both = k[1];
            apb(1, 12'h000, 32'h100541 | {pol, 3'b0} | {both, 4'b0});
            set2(0, 1); `CHK({irq, i0, i1}, {pol | both, pol | both, 1'b0})
            `CHK(o0, 1'b1)
            apb(1, 12'h000, 32'h100541 | {pol, 3'b0} | {both, 4'b0}); `CHK(i0, 1'b0)
            set2(0, 0); `CHK(i0, !pol | both)
        end
        apb(1, 12'h000, 32'h545);
        set2(0, 1); `CHK(i0, 1'b1)
        apb(0, 12'h000, 0); `CHK(rd[21], 1'b1)
        set2(0, 0); `CHK(i0, 1'b0)
        $display("test irq done");
    endtask
    task t_osc;
        logic o;
        for (int k = 0; k < 2; k++) begin
            o = k[0];
            set2(0, 0);
            apb(1, 12'h000, 32'h4103 | {o, 5'b0});
            @(posedge pclk);
            pins0 <= {3'b0, !o};
            pins1 <= {3'b0, o};
            #1; `CHK({o0, o1}, {!o, o})
            wt(6); `CHK(ro, 1'b1)
            set2(0, 0); `CHK(ro, 1'b1)
            set2(o, !o); `CHK(ro, 1'b0)
        end
        $display("test osc done");
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_mux();
        t_irq();
        t_osc();
        print_verdict();
    end
endmodule

// ### comparator_core_model.sv
`timescale 1ns/1ps
module comparator_core_model (
    // clock
    input wire logic pclk,
    // pins and controls
    input wire logic [3:0] pins0,
    input wire logic [3:0] pins1,
    input wire logic en0,
    input wire logic en1,
    input wire comparator_pkg::switch_vec_t p0,
    input wire comparator_pkg::switch_vec_t m0,
    input wire comparator_pkg::switch_vec_t p1,
    input wire comparator_pkg::switch_vec_t m1,
    // results
    output logic raw0,
    output logic raw1
);
    logic [7:0] src0, src1;
    logic tog = 1'b0;
    // ladder and bandgap taken as low, pins 0 and 1 shared
    assign src0 = {1'b0, pins1[1:0], pins0, 1'b0};
    assign src1 = {1'b0, pins0[1:0], pins1, 1'b0};
    // powered-down core output wanders
    always @(posedge pclk) tog <= ~tog;
    assign raw0 = en0 ? (|(p0 & src0) && !(|(m0 & src0))) : tog;
    assign raw1 = en1 ? (|(p1 & src1) && !(|(m1 & src1))) : ~tog;
endmodule

// ### comparator_pkg.sv
package comparator_pkg;

    // input multiplexer sources, in select-code order
    typedef enum logic [2:0] {
        SRC_LADDER,
        SRC_OWN_PIN0,
        SRC_OWN_PIN1,
        SRC_OWN_PIN2,
        SRC_OWN_PIN3,
        SRC_OTHER_PIN0,
        SRC_OTHER_PIN1,
        SRC_BANDGAP
    } input_src_t;

    // one analog switch per source
    typedef logic [7:0] switch_vec_t;

endpackage

// ### input_select.sv
`timescale 1ns/1ps
module input_select (
    // select code from the control register
    input wire logic [2:0] sel,
    // one-hot analog switch enables, index = source
    output comparator_pkg::switch_vec_t switch_vec
);

    // turn a select code into one closed switch
    function automatic comparator_pkg::switch_vec_t decode_src(input logic [2:0] code);
        comparator_pkg::switch_vec_t v;
        v = 8'h00;
        case (comparator_pkg::input_src_t'(code))
            comparator_pkg::SRC_LADDER: v[0] = 1'b1;
            comparator_pkg::SRC_OWN_PIN0: v[1] = 1'b1;
            comparator_pkg::SRC_OWN_PIN1: v[2] = 1'b1;
            comparator_pkg::SRC_OWN_PIN2: v[3] = 1'b1;
            comparator_pkg::SRC_OWN_PIN3: v[4] = 1'b1;
            comparator_pkg::SRC_OTHER_PIN0: v[5] = 1'b1;
            comparator_pkg::SRC_OTHER_PIN1: v[6] = 1'b1;
            comparator_pkg::SRC_BANDGAP: v[7] = 1'b1;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // same encoding for every multiplexer
    assign switch_vec = decode_src(sel);

endmodule
